// ===== rtl/faasl_alarm.sv
`timescale 1ns/1ns
`include "faasl_params.svh"
// How it works
// - Sync field 01 drives regulation clock out
// - Sync field 00 takes clock from pin
// - Alerts appear once pin is alert
// - Drive code 00h raises minimum alarm
// - Drive code FFh raises maximum alarm
// - Enable bits 0,1 gate min/max
// - Any tach counter at 255 overflows
// - Enable bit 2 gates overflow alarm
// - Pin pulled low alarms, any config
// - Enable bits 3,4 gate pin alarms
// - Alert stays latched after condition ends
// - Status read releases only ended alarms
// - Disabling alarm drops its alert
// - Alert pin field 01 selects alert
module faasl_alarm
   import faasl_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Register access from the serial interface
   input wire logic i_enable_we,
   input wire logic [7:0] i_enable_wdata,
   input wire logic i_pindef_we,
   input wire logic [7:0] i_pindef_wdata,
   input wire logic i_status_rd,
   // Monitored values
   input wire faasl_mon_t i_mon,
   // Pin levels
   input wire logic i_full_on_capable_pin,
   input wire logic i_sync_clock_pin,
   // Register read back
   output logic [7:0] o_alarm_enable,
   output logic [7:0] o_pindef,
   output logic [7:0] o_alarm_status,
   // Pins and clock
   output faasl_pins_t o_pins
);
   // Host registers and alarm flags
   logic [7:0] alarm_enable;
   logic [7:0] next_alarm_enable;
   logic [7:0] pindef;
   logic [7:0] next_pindef;
   logic [`FAASL_NUM_ALARMS-1:0] status;
   logic [`FAASL_NUM_ALARMS-1:0] next_status;
   logic [`FAASL_NUM_ALARMS-1:0] cond;

   // Pin synchronisers and settled levels
   logic [2:0] fo_sync;
   logic [2:0] next_fo_sync;
   logic [2:0] sc_sync;
   logic [2:0] next_sc_sync;
   logic fo_level;
   logic next_fo_level;
   logic sc_level;
   logic next_sc_level;

   // Regulation clock
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic int_clk;
   logic next_int_clk;
   logic reg_clk;
   logic next_reg_clk;

   // Pin drivers
   logic alert_oe;
   logic next_alert_oe;
   logic sync_oe;
   logic next_sync_oe;

   // Two-bit pin definition field compare
   function automatic logic field_is(input logic [7:0] r, input int lsb,
         input logic [1:0] code);
      field_is = (r[lsb +: 2] == code);
   endfunction

   // Stage one may be metastable, so it never votes
   function automatic logic settled(input logic [2:0] stages, input logic level);
      settled = (stages[1] == stages[2]) ? stages[2] : level;
   endfunction

   // A tach counter reads full scale once it has overflowed
   function automatic logic is_full(input logic [7:0] count);
      is_full = (count == `FAASL_TACH_FULL);
   endfunction

   // Register state
   always_comb begin
      next_alarm_enable = i_enable_we ? i_enable_wdata : alarm_enable;
      next_pindef = i_pindef_we ? i_pindef_wdata : pindef;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm_enable <= `FAASL_ENABLE_RESET;
         pindef <= `FAASL_PINDEF_RESET;
      end else begin
         alarm_enable <= next_alarm_enable;
         pindef <= next_pindef;
      end
   end

   // Pin synchronisers: a change counts once stages two and three agree
   always_comb begin
      next_fo_sync = {fo_sync[1:0], i_full_on_capable_pin};
      next_sc_sync = {sc_sync[1:0], i_sync_clock_pin};
      next_fo_level = settled(fo_sync, fo_level);
      next_sc_level = settled(sc_sync, sc_level);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fo_sync <= 3'h7;
         sc_sync <= 3'h7;
         fo_level <= 1'b1;
         sc_level <= 1'b1;
      end else begin
         fo_sync <= next_fo_sync;
         sc_sync <= next_sc_sync;
         fo_level <= next_fo_level;
         sc_level <= next_sc_level;
      end
   end

   // Live alarm conditions
   always_comb begin
      cond = '0;
      cond[`FAASL_BIT_MIN_OUT] = (i_mon.drive_code == `FAASL_DRIVE_MIN);
      cond[`FAASL_BIT_MAX_OUT] = (i_mon.drive_code == `FAASL_DRIVE_MAX);
      cond[`FAASL_BIT_TACH_OVF] = is_full(i_mon.tach_count_a) ||
         is_full(i_mon.tach_count_b);
      // Pin level is watched whatever the pin's own function
      cond[`FAASL_BIT_FULL_ON_LOW] = !fo_level;
      cond[`FAASL_BIT_SYNC_LOW] = !sc_level;
   end

   // Sticky status: set beats clear, read clears only ended alarms
   always_comb begin
      next_status = status;
      if (i_status_rd) begin
         next_status = status & cond;
      end
      // Enable in force this cycle gates the set; a fresh write counts next edge
      next_status = next_status
         | (cond & alarm_enable[`FAASL_NUM_ALARMS-1:0]);
      // Disabled alarms lose their flag at once
      next_status = next_status & next_alarm_enable[`FAASL_NUM_ALARMS-1:0];
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   // Internal regulation clock: free-running divider, also what a master sends
   always_comb begin
      next_div_cnt = div_cnt + 8'h01;
      next_int_clk = int_clk;
      if (div_cnt == `FAASL_REG_CLK_HALF) begin
         next_div_cnt = 8'h00;
         next_int_clk = !int_clk;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt <= 8'h00;
         int_clk <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         int_clk <= next_int_clk;
      end
   end

   // Clock source: an input follows its master a few cycles late, never glitches
   always_comb begin
      if (field_is(pindef, `FAASL_SYNC_FIELD_LSB, `FAASL_FIELD_CLK_IN)) begin
         next_reg_clk = sc_level;
      end else begin
         next_reg_clk = next_int_clk;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reg_clk <= 1'b0;
      end else begin
         reg_clk <= next_reg_clk;
      end
   end

   // Pin drivers use next values, so they move on the same edge as the registers
   always_comb begin
      // Open drain: the shared line is pulled low during the clock's low half
      next_sync_oe = field_is(next_pindef, `FAASL_SYNC_FIELD_LSB, `FAASL_FIELD_CLK_OUT)
         && !next_int_clk;
      // Open drain: pull low while any flag is set and pin is alert
      next_alert_oe = field_is(next_pindef, `FAASL_ALERT_FIELD_LSB, `FAASL_FIELD_ALERT)
         && (|next_status);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alert_oe <= 1'b0;
         sync_oe <= 1'b0;
      end else begin
         alert_oe <= next_alert_oe;
         sync_oe <= next_sync_oe;
      end
   end

   assign o_alarm_enable = alarm_enable;
   assign o_pindef = pindef;
   assign o_alarm_status = {3'h0, status};
   assign o_pins.alert_oe = alert_oe;
   assign o_pins.sync_oe = sync_oe;
   assign o_pins.sync_out = 1'b0;
   assign o_pins.reg_clk = reg_clk;
endmodule

// ===== inc/faasl_params.svh
`ifndef FAASL_PARAMS_SVH
`define FAASL_PARAMS_SVH

// Alarm bit positions, shared by enable and status
`define FAASL_BIT_MIN_OUT 0
`define FAASL_BIT_MAX_OUT 1
`define FAASL_BIT_TACH_OVF 2
`define FAASL_BIT_FULL_ON_LOW 3
`define FAASL_BIT_SYNC_LOW 4
`define FAASL_NUM_ALARMS 5

// Drive code extremes
`define FAASL_DRIVE_MIN 8'h00
`define FAASL_DRIVE_MAX 8'hff
// Tach counter saturation value
`define FAASL_TACH_FULL 8'hff

// Two-bit pin definition fields
`define FAASL_ALERT_FIELD_LSB 0
`define FAASL_SYNC_FIELD_LSB 4
`define FAASL_FIELD_ALERT 2'h1
`define FAASL_FIELD_CLK_OUT 2'h1
`define FAASL_FIELD_CLK_IN 2'h0

// Reset values
`define FAASL_ENABLE_RESET 8'h00
`define FAASL_PINDEF_RESET 8'hff

// Last divider count in each half period of the internal regulation clock; a half period is 50 core cycles
`define FAASL_REG_CLK_HALF 8'h31

`endif

// ===== inc/faasl_pkg.sv
package faasl_pkg;
   typedef struct packed {
      logic [7:0] drive_code;
      logic [7:0] tach_count_a;
      logic [7:0] tach_count_b;
   } faasl_mon_t;

   typedef struct packed {
      logic alert_oe;
      logic sync_oe;
      logic sync_out;
      logic reg_clk;
   } faasl_pins_t;
endpackage

// ===== bench/faasl_alarm_monitor.sv
`timescale 1ns/1ns
module faasl_alarm_monitor
   import faasl_pkg::*;
(
   // Watched ports
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_enable_we,
   input wire logic i_status_rd,
   input wire faasl_mon_t i_mon,
   input wire logic i_full_on_capable_pin,
   input wire logic [7:0] o_alarm_enable,
   input wire logic [7:0] o_pindef,
   input wire logic [7:0] o_alarm_status,
   input wire faasl_pins_t o_pins
);
   wire [7:0] en = o_alarm_enable;
   wire [7:0] st = o_alarm_status;
   wire we = i_enable_we;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   chk_min_flag: assert property (en[0] && !we && i_mon.drive_code == 8'h00 |=> st[0])
      else $error("min flag missing");
   chk_tach_flag: assert property (en[2] && !we && i_mon.tach_count_b == 8'hff |=> st[2])
      else $error("overflow flag missing");
   chk_gate_mask: assert property ((st & ~{3'h7, en[4:0]}) == 8'h00)
      else $error("flag without enable");
   chk_flag_hold: assert property (!i_status_rd && !we |=> (st & $past(st)) == $past(st))
      else $error("flag dropped");
   chk_read_clear: assert property (i_status_rd && !we && i_mon.drive_code != 8'h00
      |=> !st[0]) else $error("flag kept after read");
   chk_alert_pin: assert property ($stable(o_pindef)
      |-> o_pins.alert_oe == (o_pindef[1:0] == 2'h1 && st != 8'h00)) else $error("alert wrong");
   chk_pin_low: assert property ((en[3] && !we && !i_full_on_capable_pin) [*5] |=> st[3])
      else $error("pin flag missing");
   chk_sync_idle: assert property ($stable(o_pindef) && o_pindef[5:4] != 2'h1
      |-> !o_pins.sync_oe) else $error("sync pin driven");
endmodule
bind faasl_alarm faasl_alarm_monitor u_mon (.i_core_clk, .i_rst_n, .i_enable_we, .i_status_rd,
   .i_mon, .i_full_on_capable_pin, .o_alarm_enable, .o_pindef, .o_alarm_status, .o_pins);

// ===== bench/faasl_peer.sv
`timescale 1ns/1ns
module faasl_peer (
   // Shared sync line
   input wire logic i_core_clk,
   input wire logic i_clk_en,
   output logic o_sync_oe
);
   logic [2:0] cnt = 3'h0;
   always @(posedge i_core_clk) begin
      cnt <= cnt + 3'h1;
      o_sync_oe <= i_clk_en && cnt[2];
   end
endmodule

// ===== bench/tb_faasl_alarm.sv
`timescale 1ns/1ns
module tb_faasl_alarm;
   import faasl_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, en_we = 1'b0, pd_we = 1'b0, rd_s = 1'b0;
   logic full_low = 1'b0, peer_en = 1'b0, peer_oe, r;
   logic [7:0] wd = 8'h00, st, en_q, pd_q;
   faasl_mon_t mon = '{8'h80, 8'h00, 8'h00};
   faasl_pins_t pins;
   int err_count = 0, num_checks = 0;
   wire sync_pin = !(pins.sync_oe || peer_oe);
   always #5 clk = ~clk;
   faasl_alarm u_faasl_alarm (.i_core_clk(clk), .i_rst_n(rst_n), .i_enable_we(en_we),
      .i_enable_wdata(wd), .i_pindef_we(pd_we), .i_pindef_wdata(wd), .i_status_rd(rd_s),
      .i_mon(mon), .i_full_on_capable_pin(!full_low), .i_sync_clock_pin(sync_pin),
      .o_alarm_enable(en_q), .o_pindef(pd_q), .o_alarm_status(st), .o_pins(pins));
   faasl_peer u_faasl_peer (.i_core_clk(clk), .i_clk_en(peer_en), .o_sync_oe(peer_oe));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task go(input logic [5:0] c, input logic [7:0] d, input logic [7:0] code, input int n,
         input logic [7:0] exp);
      @(posedge clk);
      {peer_en, full_low, en_we, pd_we, rd_s} <= c[4:0];
      wd <= d;
      mon <= {code, 8'h00, {8{c[5]}}};
      @(posedge clk);
      {en_we, pd_we, rd_s} <= 3'h0;
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk(st, exp);
      chk({7'h00, pins.alert_oe}, {7'h00, exp != 8'h00});
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      go(6'h02, 8'h01, 8'h80, 0, 8'h00);
      chk(pd_q, 8'h01);
      go(6'h04, 8'h1f, 8'h00, 1, 8'h01);
      go(6'h00, 8'h00, 8'h80, 3, 8'h01);
      go(6'h01, 8'h00, 8'h80, 0, 8'h00);
      go(6'h00, 8'h00, 8'hff, 0, 8'h02);
      go(6'h01, 8'h00, 8'hff, 2, 8'h02);
      go(6'h04, 8'h1d, 8'hff, 0, 8'h00);
      go(6'h20, 8'h00, 8'h80, 0, 8'h04);
      go(6'h08, 8'h00, 8'h80, 5, 8'h0c);
      go(6'h01, 8'h00, 8'h80, 5, 8'h08);
      go(6'h01, 8'h00, 8'h80, 0, 8'h00);
      go(6'h02, 8'h11, 8'h80, 120, 8'h10);
      go(6'h12, 8'h01, 8'h80, 20, 8'h10);
      r = pins.reg_clk;
      chk({6'h00, pins.sync_oe, pins.sync_out}, 8'h00);
      go(6'h10, 8'h00, 8'h80, 2, 8'h10);
      chk({7'h00, r ^ pins.reg_clk}, 8'h01);
      go(6'h14, 8'h00, 8'h80, 0, 8'h00);
      chk(en_q, 8'h00);
      print_verdict;
   end
endmodule
